/* pkg/fan_ramp_regs.svh */
// Purpose: register map, field positions, resets and timing of the ramp limiter
// Assumes: 32-bit avalon words, register offsets are word indexes
// Notes: byte address is four times the index
`ifndef FAN_RAMP_REGS_SVH
`define FAN_RAMP_REGS_SVH
// --------------------------------------------------------------------
// register indexes
// --------------------------------------------------------------------
`define ACOUSTIC_FIRST_IDX 8'h62
`define ACOUSTIC_SECOND_IDX 8'h63
`define DUTY_ONE_IDX 8'h30
`define DUTY_TWO_IDX 8'h31
`define DUTY_THREE_IDX 8'h32
`define EVT_STATUS_IDX 8'h64
`define EVT_MASK_IDX 8'h65
// --------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------
`define EN_ONE_BIT 3
`define EN_TWO_BIT 7
`define EN_THREE_BIT 3
`define STEP_ONE_LSB 0
`define STEP_TWO_LSB 4
`define STEP_THREE_LSB 0
`define ST_SETTLED_LSB 0
`define ST_SUPPLY_LSB 3
// --------------------------------------------------------------------
// reset values and timing
// --------------------------------------------------------------------
`define ACOUSTIC_RESET 8'h00
`define DUTY_RESET 8'hFF
`define EVT_RESET 8'h00
`define SLOT_LAST 8'hFE
`define CLK_HZ 50000000
`define FULL_RAMP_MS 35000
`define UPDATE_CYCLES ((`FULL_RAMP_MS * (`CLK_HZ / 1000)) / 255)
`endif

/* pkg/fan_ramp_pkg.sv */
// Purpose: shared types of the ramp limiter
// Assumes: three fan drive outputs
// Notes: constants live in fan_ramp_regs.svh
package fan_ramp_pkg;
	// one duty value per fan drive output
	typedef struct packed {
		logic [7:0] three;
		logic [7:0] two;
		logic [7:0] one;
	} duty_set_t;
	// the three pwm pins
	typedef struct packed {
		logic fan_drive_three;
		logic fan_drive_two;
		logic fan_drive_one;
	} fan_pins_t;
	// register bus answer sequencing
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} bus_state_t;
endpackage

/* hw/fan_duty_ramp_limiter.sv */
// Purpose: slew-rate limit three fan pwm duties toward computed targets
// Assumes: targets and supply faults come from logic on clk_in
// Notes: registers over avalon-mm, one wait state per access
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`include "fan_ramp_regs.svh"

module fan_duty_ramp_limiter #(
	parameter int UPDATE_CYCLES = `UPDATE_CYCLES,
	parameter int SLOT_CYCLES = 1,
	parameter int SUPPLY_CH = 5
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire fan_ramp_pkg::duty_set_t duty_target_in,
	input wire logic [SUPPLY_CH-1:0] supply_fault_in,
	input wire logic [9:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output fan_ramp_pkg::duty_set_t duty_now_out,
	output fan_ramp_pkg::fan_pins_t fan_pins_out,
	output logic irq_out
);
	import fan_ramp_pkg::*;

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------

	// step code to timeslots per update
	function automatic logic [7:0] step_of(input logic [2:0] code);
		logic [7:0] s;
		s = 8'h01;
		unique case (code)
			3'h0: s = 8'h01;
			3'h1: s = 8'h02;
			3'h2: s = 8'h03;
			3'h3: s = 8'h05;
			3'h4: s = 8'h08;
			3'h5: s = 8'h0C;
			3'h6: s = 8'h18;
			3'h7: s = 8'h30;
		endcase
		return s;
	endfunction

	// one limited move of prev toward target
	function automatic logic [7:0] ramp_to(input logic [7:0] prev,
		input logic [7:0] tgt, input logic [7:0] step);
		logic [8:0] sum;
		logic [7:0] r;
		sum = {1'b0, prev} + {1'b0, step};
		r = prev;
		if (tgt > prev) begin
			// never past target, never past full scale
			if ((tgt - prev) < step) begin
				r = tgt;
			end else if (sum[8]) begin
				r = 8'hFF;
			end else begin
				r = sum[7:0];
			end
		end else if (tgt < prev) begin
			// a small gap also covers underflow below zero
			if ((prev - tgt) < step) begin
				r = tgt;
			end else begin
				r = prev - step;
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	logic [7:0] acoustic_ctrl_first; // enable one and step one
	logic [7:0] acoustic_ctrl_second; // enables two/three and their steps
	logic [7:0] evt_status; // sticky event bits
	logic [7:0] evt_mask; // one hides the matching status bit
	bus_state_t bus_state; // wait state sequencer

	// ----------------------------------------------------------------
	// field decode
	// ----------------------------------------------------------------
	wire [2:0] ramp_en; // per-output limiter enable
	wire [7:0] step [3]; // per-output step in timeslots
	wire [2:0] ramp_step_sel_one;
	wire [2:0] ramp_step_sel_two;
	wire [2:0] ramp_step_sel_three;
	assign ramp_en[0] = acoustic_ctrl_first[`EN_ONE_BIT];
	assign ramp_en[1] = acoustic_ctrl_second[`EN_TWO_BIT];
	assign ramp_en[2] = acoustic_ctrl_second[`EN_THREE_BIT];
	assign ramp_step_sel_one =
		acoustic_ctrl_first[`STEP_ONE_LSB +: 3];
	assign ramp_step_sel_two =
		acoustic_ctrl_second[`STEP_TWO_LSB +: 3];
	assign ramp_step_sel_three =
		acoustic_ctrl_second[`STEP_THREE_LSB +: 3];
	assign step[0] = step_of(ramp_step_sel_one);
	assign step[1] = step_of(ramp_step_sel_two);
	assign step[2] = step_of(ramp_step_sel_three);

	// ----------------------------------------------------------------
	// update tick
	// ----------------------------------------------------------------
	// one update per 255th of the unit-step full ramp time, so step
	// one crosses full scale in about 35 s and step 48 in about 0.8 s
	logic [31:0] tick_cnt;
	wire tick;
	assign tick = (tick_cnt == 32'(UPDATE_CYCLES - 1));

	// free-running update divider
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tick_cnt <= 32'h0;
		end else if (tick) begin
			tick_cnt <= 32'h0;
		end else begin
			tick_cnt <= tick_cnt + 32'h1;
		end
	end

	// ----------------------------------------------------------------
	// ramp datapath
	// ----------------------------------------------------------------
	logic [7:0] duty [3]; // previous duty, the comparison base
	wire [7:0] target [3]; // newest computed duty
	wire [7:0] next_duty [3]; // limited move toward target
	wire [2:0] settled; // pulse: a ramp just reached target
	assign target[0] = duty_target_in.one;
	assign target[1] = duty_target_in.two;
	assign target[2] = duty_target_in.three;

	// each output has its own base, step and enable
	for (genvar i = 0; i < 3; i++) begin : g_ramp
		assign next_duty[i] = ramp_to(duty[i], target[i], step[i]);
		assign settled[i] = ramp_en[i] && tick &&
			(duty[i] != target[i]) && (next_duty[i] == target[i]);

		// limited outputs move only on a tick; the others follow
		// the target one clock later, without waiting for a tick
		always_ff @(posedge clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				duty[i] <= `DUTY_RESET;
			end else if (!ramp_en[i]) begin
				duty[i] <= target[i];
			end else if (tick) begin
				duty[i] <= next_duty[i];
			end
		end
	end

	assign duty_now_out = '{three: duty[2], two: duty[1], one: duty[0]};

	// ----------------------------------------------------------------
	// pwm generation
	// ----------------------------------------------------------------
	// slot counter runs 0..254; duty 255 therefore means always high
	logic [7:0] slot_cnt; // current timeslot
	logic [31:0] slot_div; // cycles inside the timeslot
	wire slot_end;
	wire [2:0] next_pin;
	assign slot_end = (slot_div == 32'(SLOT_CYCLES - 1));
	assign next_pin[0] = (slot_cnt < duty[0]);
	assign next_pin[1] = (slot_cnt < duty[1]);
	assign next_pin[2] = (slot_cnt < duty[2]);

	// timeslot prescaler and slot counter
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			slot_div <= 32'h0;
			slot_cnt <= 8'h00;
		end else if (slot_end) begin
			slot_div <= 32'h0;
			slot_cnt <= (slot_cnt == `SLOT_LAST) ? 8'h00 : slot_cnt + 8'h01;
		end else begin
			slot_div <= slot_div + 32'h1;
		end
	end

	// pins come from flops to keep them glitch free
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fan_pins_out <= '0;
		end else begin
			fan_pins_out <= '{fan_drive_three: next_pin[2],
				fan_drive_two: next_pin[1], fan_drive_one: next_pin[0]};
		end
	end

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	wire [7:0] idx; // word index from byte address
	wire req; // any request present
	wire commit; // the edge at which the access completes
	wire wr_lane0; // low byte written
	wire [7:0] rd_val; // decoded read value
	wire [7:0] status_set; // events raised this cycle
	wire [7:0] status_clr; // write-one-to-clear bits
	assign idx = avs_address_in[9:2];
	assign req = avs_read_in | avs_write_in;
	assign commit = req && (bus_state == BUS_ACK);
	assign wr_lane0 = commit && avs_write_in && avs_byteenable_in[0];
	// one wait state: request seen, answer ready the next cycle
	assign avs_waitrequest_out = req && (bus_state == BUS_IDLE);
	assign rd_val =
		(idx == `ACOUSTIC_FIRST_IDX) ? acoustic_ctrl_first :
		(idx == `ACOUSTIC_SECOND_IDX) ? acoustic_ctrl_second :
		(idx == `DUTY_ONE_IDX) ? duty[0] :
		(idx == `DUTY_TWO_IDX) ? duty[1] :
		(idx == `DUTY_THREE_IDX) ? duty[2] :
		(idx == `EVT_STATUS_IDX) ? evt_status :
		(idx == `EVT_MASK_IDX) ? evt_mask : 8'h00;

	// bus sequencer; read data is latched with the wait state
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bus_state <= BUS_IDLE;
			avs_readdata_out <= 32'h0;
		end else begin
			unique case (bus_state)
				BUS_IDLE: begin
					if (req) begin
						bus_state <= BUS_ACK;
						avs_readdata_out <= {24'h0, rd_val};
					end
				end
				BUS_ACK: begin
					bus_state <= BUS_IDLE;
				end
			endcase
		end
	end

	// configuration writes; the duty readbacks ignore writes
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			acoustic_ctrl_first <= `ACOUSTIC_RESET;
			acoustic_ctrl_second <= `ACOUSTIC_RESET;
			evt_mask <= `EVT_RESET;
		end else if (wr_lane0) begin
			if (idx == `ACOUSTIC_FIRST_IDX) begin
				acoustic_ctrl_first <= avs_writedata_in[7:0];
			end
			if (idx == `ACOUSTIC_SECOND_IDX) begin
				acoustic_ctrl_second <= avs_writedata_in[7:0];
			end
			if (idx == `EVT_MASK_IDX) begin
				evt_mask <= avs_writedata_in[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// events and interrupt
	// ----------------------------------------------------------------
	// supply faults keep raising status while powered down; only the
	// mask stops the alert, so software must mask before sleeping
	assign status_set = {supply_fault_in, settled};
	assign status_clr = (wr_lane0 && idx == `EVT_STATUS_IDX) ?
		avs_writedata_in[7:0] : 8'h00;

	// sticky status: a set in the clearing cycle wins
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			evt_status <= `EVT_RESET;
		end else begin
			evt_status <= (evt_status & ~status_clr) | status_set;
		end
	end

	// level alert while any unmasked bit stands
	assign irq_out = |(evt_status & ~evt_mask);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	step_up_a: assert property (
		ramp_en[0] && tick && target[0] > duty[0] &&
		(target[0] - duty[0]) >= step[0] && !$changed(acoustic_ctrl_first)
		|=> duty[0] == 8'($past(duty[0]) + $past(step[0])))
		else $error("duty one did not rise by one step");

	step_down_a: assert property (
		ramp_en[0] && tick && target[0] < duty[0] &&
		(duty[0] - target[0]) >= step[0]
		|=> duty[0] == 8'($past(duty[0]) - $past(step[0])))
		else $error("duty one did not fall by one step");

	land_exact_a: assert property (
		ramp_en[1] && tick && duty[1] != target[1] &&
		(target[1] - duty[1]) < step[1] && target[1] > duty[1]
		|=> duty[1] == $past(target[1]))
		else $error("duty two overshot its target");

	hold_between_a: assert property (
		ramp_en[0] && !tick && $past(ramp_en[0]) |=> $stable(duty[0]))
		else $error("limited duty moved without a tick");

	bypass_two_a: assert property (
		!ramp_en[1] |=> duty[1] == $past(target[1]))
		else $error("unlimited duty two did not follow target");

	hold_three_a: assert property (
		ramp_en[2] && !tick |=> $stable(duty[2]))
		else $error("limited duty three moved without a tick");

	slot_range_a: assert property (
		slot_cnt != 8'hFF)
		else $error("timeslot counter left 0..254");

	zero_duty_a: assert property (
		duty[0] == 8'h00 && $past(duty[0]) == 8'h00 |=>
		!fan_pins_out.fan_drive_one)
		else $error("zero duty drove pin one high");

	step_max_a: assert property (
		ramp_step_sel_two == 3'h7 |-> step[1] == 8'h30)
		else $error("code 7 did not give 48 timeslots");

	// a clear by software may drop the bit, unless a fault sets it again
	supply_sticky_a: assert property (
		supply_fault_in[0] ||
		(evt_status[`ST_SUPPLY_LSB] && !status_clr[`ST_SUPPLY_LSB])
		|=> evt_status[`ST_SUPPLY_LSB])
		else $error("supply fault status did not stick");

	alert_mask_a: assert property (
		evt_status[`ST_SUPPLY_LSB] && !evt_mask[`ST_SUPPLY_LSB] |-> irq_out)
		else $error("unmasked supply fault gave no alert");

	bus_answer_a: assert property (
		req && bus_state == BUS_IDLE |=> !avs_waitrequest_out)
		else $error("bus answer not ready after one wait state");

	// a landing tick must leave its sticky flag behind
	settle_sticky_a: assert property (
		settled[0] |=> evt_status[`ST_SETTLED_LSB])
		else $error("landing on target left no status");

	bypass_one_a: assert property (
		!ramp_en[0] |=> duty[0] == $past(target[0]))
		else $error("unlimited duty one did not follow target");

	step_three_a: assert property (
		ramp_en[2] && tick && target[2] > duty[2] &&
		(target[2] - duty[2]) >= step[2]
		|=> duty[2] == 8'($past(duty[2]) + $past(step[2])))
		else $error("duty three did not rise by one step");

	settle_cv: cover property (settled[0]);
	ramp_up_cv: cover property (ramp_en[1] && tick && target[1] > duty[1]);
	alert_cv: cover property (irq_out && supply_fault_in != '0);
	read_cv: cover property (avs_read_in && !avs_waitrequest_out);
	ramp_down_cv: cover property (ramp_en[2] && tick && target[2] < duty[2]);

endmodule // fan_duty_ramp_limiter

/* testbench/fan_model.sv */
// Purpose: pwm fan stand-in that reports the high slots it saw
// Assumes: one slot per clock, a period of 255 slots
// Notes: free running window, so only a steady duty reads true
`timescale 1ns/1ps
module fan_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic pin_in,
	output logic [7:0] seen_duty_out
);
	int slot; // position inside the window
	int highs; // high slots counted so far
	// any 255 slot window of a steady pwm holds exactly duty highs
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			slot <= 0;
			highs <= 0;
			seen_duty_out <= 8'h00;
		end else if (slot == 254) begin
			seen_duty_out <= 8'(highs + pin_in);
			slot <= 0;
			highs <= 0;
		end else begin
			slot <= slot + 1;
			highs <= highs + pin_in;
		end
	end
endmodule // fan_model

/* testbench/fan_duty_ramp_limiter_test.sv */
// Purpose: self-checking bench of the fan duty ramp limiter
// Assumes: update interval cut to 8 clocks, one clock per slot
// Notes: reset first, then ramp rows, independence, pwm, bus and event cases
`timescale 1ns/1ps
`include "fan_ramp_regs.svh"
module fan_duty_ramp_limiter_test;
	import fan_ramp_pkg::*;
	localparam int UPD = 8; // short tick keeps the run brief
	typedef struct {
		logic [2:0] code;
		logic [7:0] from, to, first;
		int ticks;
	} row_t;
	// rising rows for every code, two falling rows; ticks to land
	row_t rows [10] = '{'{0, 0, 8'hFF, 8'h01, 255},
		'{1, 0, 8'hFF, 8'h02, 128}, '{2, 0, 8'hFF, 8'h03, 85},
		'{3, 0, 8'hFF, 8'h05, 51}, '{4, 0, 8'hFF, 8'h08, 32},
		'{5, 0, 8'hFF, 8'h0C, 22}, '{6, 0, 8'hFF, 8'h18, 11},
		'{7, 0, 8'hFF, 8'h30, 6}, '{3, 8'hFF, 0, 8'hFA, 51},
		'{7, 8'hFF, 0, 8'hCF, 6}};
	logic clk_in = 0;
	logic rst_n_in = 0;
	duty_set_t tgt = '0; // computed target duties
	logic [4:0] fault = '0; // supply faults
	logic [9:0] addr = '0;
	logic rd = 0;
	logic wr = 0;
	logic [31:0] wdata = '0;
	logic [3:0] be = 4'hF;
	logic [31:0] rdata;
	logic wait_req;
	duty_set_t duty;
	fan_pins_t pins;
	logic irq;
	logic [7:0] seen [3]; // duty measured by each fan
	int fail_count = 0;
	int comparisons = 0;
	logic [31:0] r;
	logic [7:0] f;
	int t;
	int w; // wait states of the last access
	always #10 clk_in = ~clk_in;
	fan_duty_ramp_limiter #(.UPDATE_CYCLES(UPD)) i_fan_duty_ramp_limiter (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .duty_target_in(tgt),
		.supply_fault_in(fault), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
		.avs_byteenable_in(be), .avs_readdata_out(rdata),
		.avs_waitrequest_out(wait_req), .duty_now_out(duty),
		.fan_pins_out(pins), .irq_out(irq));
	for (genvar k = 0; k < 3; k++) begin : g_fan
		fan_model i_fan_model (.clk_in(clk_in), .rst_n_in(rst_n_in),
			.pin_in(pins[k]), .seen_duty_out(seen[k]));
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	// one avalon access, held until waitrequest is seen low
	task automatic bus(input logic we, input logic [7:0] idx, d);
		@(posedge clk_in);
		addr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		rd <= !we;
		wr <= we;
		w = -1;
		// the edge that sees waitrequest low also takes the read data
		do begin
			@(posedge clk_in);
			w++;
		end while (wait_req !== 1'b0);
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rchk(input string what, input logic [7:0] idx, exp);
		bus(0, idx, 0);
		chk(what, r, {24'h0, exp});
	endtask
	function automatic logic [7:0] dv(input int i);
		return duty[i*8 +: 8];
	endfunction
	// ramp output i to a new target; first step and ticks to land
	task automatic ramp(input int i, input logic [7:0] from, to);
		int c = 0;
		int c1 = 0;
		tgt[i*8 +: 8] <= to;
		while (dv(i) !== to && c < 4000) begin
			@(posedge clk_in);
			#1;
			c++;
			if (c1 == 0 && dv(i) !== from) begin
				c1 = c;
				f = dv(i);
			end
		end
		t = (c - c1) / UPD + 1; // whole ticks, so the lag cancels
	endtask
	// preload all outputs with ramping off: they copy the target
	task automatic preload(input logic [7:0] v);
		bus(1, `ACOUSTIC_FIRST_IDX, 0);
		bus(1, `ACOUSTIC_SECOND_IDX, 0);
		tgt <= {v, v, v};
		repeat (3) @(posedge clk_in);
	endtask
	task automatic end_sim();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// watchdog far beyond the few thousand cycles the tests need
	initial begin
		#(20 * 40000);
		fail_count++;
		end_sim();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		@(posedge clk_in);
		#1;
		chk("duty in reset", duty, 24'hFFFFFF);
		chk("irq in reset", irq, 0);
		chk("pins in reset", pins, 0);
		chk("readdata in reset", rdata, 0);
		// release on the second edge, by non-blocking assignment
		@(posedge clk_in);
		rst_n_in <= 1'b1;
		rchk("first ctrl reset", `ACOUSTIC_FIRST_IDX, 8'h00);
		rchk("second ctrl reset", `ACOUSTIC_SECOND_IDX, 8'h00);
		rchk("mask reset", `EVT_MASK_IDX, 8'h00);
		$display("reset test done");
		foreach (rows[n]) begin
			preload(rows[n].from);
			bus(1, `ACOUSTIC_FIRST_IDX, {5'h01, rows[n].code});
			ramp(0, rows[n].from, rows[n].to);
			chk("first step", f, rows[n].first);
			chk("ticks", t, rows[n].ticks);
			chk("landed", dv(0), rows[n].to);
		end
		rchk("duty readback", `DUTY_ONE_IDX, 8'h00);
		$display("ramp table done");
		// one copies, two steps by 48, three by 8, all from one target
		preload(8'h00);
		bus(1, `ACOUSTIC_SECOND_IDX, 8'hFC);
		rchk("second ctrl", `ACOUSTIC_SECOND_IDX, 8'hFC);
		tgt <= 24'hFFFFFF;
		// any UPD edges after the change hold exactly one tick
		repeat (UPD) @(posedge clk_in);
		#1;
		chk("two first", dv(1), 8'h30);
		chk("three first", dv(2), 8'h08);
		chk("one copies", dv(0), 8'hFF);
		repeat (UPD) @(posedge clk_in);
		#1;
		chk("two second", dv(1), 8'h60);
		chk("three second", dv(2), 8'h10);
		$display("independence test done");
		// pwm high slots of 85, 0 and 255
		preload(8'h00);
		tgt <= {8'hFF, 8'h00, 8'h55};
		repeat (600) @(posedge clk_in);
		#1;
		chk("pwm one", seen[0], 8'h55);
		chk("pwm two", seen[1], 8'h00);
		chk("pwm three", seen[2], 8'hFF);
		$display("pwm test done");
		// refused accesses
		rchk("unmapped", 8'h10, 8'h00);
		chk("wait states", w, 1);
		bus(1, `DUTY_ONE_IDX, 8'h12);
		rchk("duty read only", `DUTY_ONE_IDX, 8'h55);
		be <= 4'h0;
		bus(1, `ACOUSTIC_FIRST_IDX, 8'hAB);
		be <= 4'hF;
		rchk("byteenable off", `ACOUSTIC_FIRST_IDX, 8'h00);
		$display("bus test done");
		// supply events: sticky, masked, cleared by writing ones
		bus(1, `EVT_MASK_IDX, 8'h77);
		bus(1, `EVT_STATUS_IDX, 8'hFF);
		fault <= 5'h11;
		@(posedge clk_in);
		fault <= 5'h00;
		repeat (2) @(posedge clk_in);
		#1;
		chk("irq raised", irq, 1);
		rchk("status", `EVT_STATUS_IDX, 8'h88);
		bus(1, `EVT_MASK_IDX, 8'hFF);
		#1;
		chk("irq masked", irq, 0);
		bus(1, `EVT_STATUS_IDX, 8'h88);
		rchk("status cleared", `EVT_STATUS_IDX, 8'h00);
		$display("event test done");
		end_sim();
	end
endmodule // fan_duty_ramp_limiter_test
